// [logic/rsi_cause_sort.sv]
// priority sorter of reset and wake events into one cause
`timescale 1ns/1ps
module rsi_cause_sort (
  // detector events
  input  wire rsi_pkg::rsi_evt_t   evt,
  // core is asleep
  input  wire logic                sleeping,
  // sorted cause
  output rsi_pkg::rsi_cause_t      cause
);

  // ****************************************************************
  // priority chain
  // ****************************************************************
  // power-on beats brown-out, both beat pin and watchdog
  assign cause = evt.por ? rsi_pkg::CAUSE_POR :
                 evt.bor ? rsi_pkg::CAUSE_BOR :
                 evt.pin ? (sleeping ? rsi_pkg::CAUSE_PIN_SLEEP
                                     : rsi_pkg::CAUSE_PIN_RUN) :
                 evt.wdt ? (sleeping ? rsi_pkg::CAUSE_WDT_WAKE
                                     : rsi_pkg::CAUSE_WDT_RESET) :
                 // an interrupt only wakes; while running it is not ours
                 (evt.irq && sleeping) ? rsi_pkg::CAUSE_IRQ_WAKE :
                 rsi_pkg::CAUSE_NONE;

endmodule

// [logic/rsi_defines.svh]
// offsets, bit positions, reset values and masks of the reset initializer
`ifndef RSI_DEFINES_SVH
`define RSI_DEFINES_SVH

// ****************************************************************
// register byte offsets on the apb bus
// ****************************************************************
`define RSI_OFF_PC        8'h00
`define RSI_OFF_STATUS    8'h04
`define RSI_OFF_POWER_CONTROL_REG      8'h08
`define RSI_OFF_OPTION    8'h0c
`define RSI_OFF_DIR0      8'h10
`define RSI_OFF_TIMER1_CONTROL_REG     8'h24
`define RSI_OFF_PR2       8'h28
`define RSI_OFF_INTERRUPT_CONTROL_REG    8'h2c
`define RSI_OFF_PIRA      8'h30
`define RSI_OFF_PIRB      8'h34
`define RSI_OFF_CAUSE     8'h38
`define RSI_DIR_STRIDE    8'h04

// ****************************************************************
// field positions
// ****************************************************************
`define RSI_ST_TO         4
`define RSI_ST_PD         3
`define RSI_POWER_CONTROL_REG_POR      1
`define RSI_POWER_CONTROL_REG_BOR      0
`define RSI_INTERRUPT_CONTROL_REG_GIE    7

// ****************************************************************
// values and implemented-bit masks
// ****************************************************************
`define RSI_PC_RESET      13'h0000
`define RSI_PC_VECTOR     13'h0004
`define RSI_ALL_ONES      8'hff
`define RSI_ST_RESET      8'h18
`define RSI_MASK_POWER_CONTROL_REG     8'h03
`define RSI_MASK_TIMER1_CONTROL_REG    8'h3f
`define RSI_MASK_PIRB     8'h01
`define RSI_MASK_DIR_A    8'h3f
`define RSI_MASK_DIR_E    8'hf7
`define RSI_DIR_E_RESET   8'h07
`define RSI_NUM_DIRS      5

`endif

// [logic/rsi_pkg.sv]
// types shared by the reset initializer files
package rsi_pkg;

  // ****************************************************************
  // reset and wake causes, highest priority first
  // ****************************************************************
  typedef enum logic [2:0] {
    CAUSE_NONE,
    CAUSE_POR,
    CAUSE_BOR,
    CAUSE_PIN_RUN,
    CAUSE_PIN_SLEEP,
    CAUSE_WDT_RESET,
    CAUSE_WDT_WAKE,
    CAUSE_IRQ_WAKE
  } rsi_cause_t;

  // one-cycle pulses from the reset-cause detectors
  typedef struct packed {
    logic por;
    logic bor;
    logic pin;
    logic wdt;
    logic irq;
  } rsi_evt_t;

  // interrupt flags raised by the source that woke the core
  typedef struct packed {
    logic [7:0] interrupt_control_reg;
    logic [7:0] pira;
    logic [0:0] pirb;
  } rsi_flags_t;

endpackage

// [logic/rsi_reset_init.sv]
// reset-condition initializer with apb register access
//
// What this block does
// - pin reset running: pc zero, top status cleared
// - pin reset asleep: pc zero, status 00010uuu
// - interrupt wake: timeout set, power-down cleared
// - interrupt wake with global enable: vector
// - interrupt wake leaves a visible interrupt flag set
// - unimplemented bits always read zero
// - power-on/brown-out: option, period ones; directions ones, port e 07
// - timer1 control clears on power/brown-out only
// - unchanged bits keep value across the event
// - pin/watchdog reset: flags by cause, top clear
// - power-on flag clears only on power-on
// - brown-out flag clears on brown-out reset
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`include "rsi_defines.svh"
module rsi_reset_init #(
  parameter int PC_W = 13
) (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // reset-cause detectors and core state
  input  wire rsi_pkg::rsi_evt_t    evt,
  input  wire logic                 sleeping,
  input  wire rsi_pkg::rsi_flags_t  wake_flags,
  // initialized register values toward the core
  output logic      [PC_W-1:0]      pc_value,
  output logic      [7:0]           status_value,
  output logic      [7:0]           power_control_reg_value,
  output logic      [7:0]           option_value,
  output logic      [39:0]          dir_value,
  output logic      [7:0]           timer1_control_reg_value,
  output logic      [7:0]           pr2_value,
  output logic      [7:0]           interrupt_control_reg_value,
  output rsi_pkg::rsi_cause_t       cause_value
);

  // ****************************************************************
  // helper functions
  // ****************************************************************
  // apply an apb write to one register through its implemented mask
  function automatic logic [7:0] wmerge(input logic hit,
                                        input logic [7:0] cur,
                                        input logic [7:0] data,
                                        input logic [7:0] mask);
    wmerge = hit ? (data & mask) : (cur & mask);
  endfunction

  // status value for each cause; u bits come from the current value
  function automatic logic [7:0] st_for(input rsi_pkg::rsi_cause_t c,
                                        input logic [7:0] cur);
    case (c)
      rsi_pkg::CAUSE_POR:       st_for = {5'b00011, cur[2:0]};
      rsi_pkg::CAUSE_BOR:       st_for = {5'b00011, cur[2:0]};
      rsi_pkg::CAUSE_PIN_RUN:   st_for = {3'b000, cur[4:0]};
      rsi_pkg::CAUSE_PIN_SLEEP: st_for = {5'b00010, cur[2:0]};
      rsi_pkg::CAUSE_WDT_RESET: st_for = {5'b00001, cur[2:0]};
      rsi_pkg::CAUSE_WDT_WAKE:  st_for = {cur[7:5], 2'b00, cur[2:0]};
      rsi_pkg::CAUSE_IRQ_WAKE:  st_for = {cur[7:5], 2'b10, cur[2:0]};
      default:                  st_for = cur;
    endcase
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic [PC_W-1:0]  pc_reg;        // program counter image
  logic [7:0]       status_reg;    // status with timeout/power-down
  logic [7:0]       power_control_reg_reg;      // power-on and brown-out flags
  logic [7:0]       option_reg;    // option register
  logic [7:0]       dir_reg [5];   // port direction registers a..e
  logic [7:0]       timer1_control_reg_reg;     // timer1 control
  logic [7:0]       pr2_reg;       // timer2 period
  logic [7:0]       interrupt_control_reg_reg;    // interrupt control
  logic [7:0]       pira_reg;      // peripheral flags a
  logic [7:0]       pirb_reg;      // peripheral flags b, one bit
  rsi_pkg::rsi_cause_t cause_reg;  // last sorted cause
  logic [31:0]      prdata_reg;    // read data to master
  logic             pready_reg;    // access-phase answer
  logic             pslverr_reg;   // unmapped address answer

  // ****************************************************************
  // cause sorting
  // ****************************************************************
  rsi_pkg::rsi_cause_t cause;      // this cycle's cause
  rsi_cause_sort u_sort (
    .evt      (evt),
    .sleeping (sleeping),
    .cause    (cause)
  );

  // grouped cause classes
  wire full_rst = (cause == rsi_pkg::CAUSE_POR) ||
                  (cause == rsi_pkg::CAUSE_BOR);
  wire pin_wdt  = (cause == rsi_pkg::CAUSE_PIN_RUN)   ||
                  (cause == rsi_pkg::CAUSE_PIN_SLEEP) ||
                  (cause == rsi_pkg::CAUSE_WDT_RESET);
  wire any_rst  = full_rst || pin_wdt;
  wire irq_wake = (cause == rsi_pkg::CAUSE_IRQ_WAKE);
  wire wdt_wake = (cause == rsi_pkg::CAUSE_WDT_WAKE);
  wire any_wake = irq_wake || wdt_wake;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  // the answer comes one cycle into the access phase
  wire apb_start = psel && penable && !pready_reg;
  // writes land only on the edge where pready is seen high
  wire apb_fin   = psel && penable && pready_reg;
  wire apb_wr    = apb_fin && pwrite;
  wire [7:0] wd  = pwdata[7:0];
  wire [7:0] dir_base = paddr - `RSI_OFF_DIR0;
  wire dir_hit   = (paddr >= `RSI_OFF_DIR0) && (paddr < `RSI_OFF_TIMER1_CONTROL_REG)
                   && (paddr[1:0] == 2'b00);
  wire [2:0] dir_idx = dir_base[4:2];
  wire mapped    = (paddr[1:0] == 2'b00) && (paddr <= `RSI_OFF_CAUSE);

  // write-merged current values; a reset or wake below overrides them
  wire [PC_W-1:0] pc_cur = (apb_wr && paddr == `RSI_OFF_PC)
                           ? pwdata[PC_W-1:0] : pc_reg;
  wire [7:0] st_cur  = wmerge(apb_wr && paddr == `RSI_OFF_STATUS,
                              status_reg, wd, `RSI_ALL_ONES);
  wire [7:0] pc_con  = wmerge(apb_wr && paddr == `RSI_OFF_POWER_CONTROL_REG,
                              power_control_reg_reg, wd, `RSI_MASK_POWER_CONTROL_REG);
  wire [7:0] opt_cur = wmerge(apb_wr && paddr == `RSI_OFF_OPTION,
                              option_reg, wd, `RSI_ALL_ONES);
  wire [7:0] t1_cur  = wmerge(apb_wr && paddr == `RSI_OFF_TIMER1_CONTROL_REG,
                              timer1_control_reg_reg, wd, `RSI_MASK_TIMER1_CONTROL_REG);
  wire [7:0] pr2_cur = wmerge(apb_wr && paddr == `RSI_OFF_PR2,
                              pr2_reg, wd, `RSI_ALL_ONES);
  wire [7:0] ic_cur  = wmerge(apb_wr && paddr == `RSI_OFF_INTERRUPT_CONTROL_REG,
                              interrupt_control_reg_reg, wd, `RSI_ALL_ONES);
  wire [7:0] pa_cur  = wmerge(apb_wr && paddr == `RSI_OFF_PIRA,
                              pira_reg, wd, `RSI_ALL_ONES);
  wire [7:0] pb_cur  = wmerge(apb_wr && paddr == `RSI_OFF_PIRB,
                              pirb_reg, wd, `RSI_MASK_PIRB);

  // ****************************************************************
  // next values per cause
  // ****************************************************************
  // resets zero the pc; wakes step it or take the vector
  wire global_irq_enable = interrupt_control_reg_reg[`RSI_INTERRUPT_CONTROL_REG_GIE];
  wire [PC_W-1:0] pc_next =
    any_rst             ? `RSI_PC_RESET :
    (irq_wake && global_irq_enable)   ? `RSI_PC_VECTOR :
    any_wake            ? PC_W'(pc_reg + 1'b1) : pc_cur;

  // status bits follow the cause, u bits kept
  wire [7:0] status_next = st_for(cause, st_cur);

  // power-on clears only its flag, brown-out only its own
  wire [7:0] power_control_reg_next =
    (cause == rsi_pkg::CAUSE_POR) ? {6'h00, 1'b0, pc_con[0]} :
    (cause == rsi_pkg::CAUSE_BOR) ? {6'h00, pc_con[1], 1'b0} :
    pc_con;

  // option forced to ones on every reset, kept on wakes
  wire [7:0] option_next = any_rst ? `RSI_ALL_ONES : opt_cur;

  // timer1 control clears only on power-on or brown-out
  wire [7:0] timer1_control_reg_next = full_rst ? 8'h00 : t1_cur;

  // timer2 period is ones after every reset and wake
  wire [7:0] pr2_next = (cause != rsi_pkg::CAUSE_NONE)
                        ? `RSI_ALL_ONES : pr2_cur;

  // reset clears all but interrupt control bit 0; an interrupt wake sets its flags
  // on top of any software clear in the same cycle
  wire [7:0] interrupt_control_reg_next = any_rst  ? {7'h00, ic_cur[0]} :
                           irq_wake ? (ic_cur | wake_flags.interrupt_control_reg) :
                           ic_cur;
  wire [7:0] pira_next   = any_rst  ? 8'h00 :
                           irq_wake ? (pa_cur | wake_flags.pira) :
                           pa_cur;
  wire [7:0] pirb_next   = any_rst  ? 8'h00 :
                           irq_wake ? (pb_cur | {7'h00, wake_flags.pirb}) :
                           pb_cur;

  // ****************************************************************
  // read mux
  // ****************************************************************
  wire [7:0] dir_rd = (dir_hit && dir_idx < 3'(`RSI_NUM_DIRS))
                      ? dir_reg[dir_idx] : 8'h00;
  wire [31:0] rd_mux =
    (paddr == `RSI_OFF_PC)     ? {{(32-PC_W){1'b0}}, pc_reg} :
    (paddr == `RSI_OFF_STATUS) ? {24'h000000, status_reg} :
    (paddr == `RSI_OFF_POWER_CONTROL_REG)   ? {24'h000000, power_control_reg_reg} :
    (paddr == `RSI_OFF_OPTION) ? {24'h000000, option_reg} :
    dir_hit                    ? {24'h000000, dir_rd} :
    (paddr == `RSI_OFF_TIMER1_CONTROL_REG)  ? {24'h000000, timer1_control_reg_reg} :
    (paddr == `RSI_OFF_PR2)    ? {24'h000000, pr2_reg} :
    (paddr == `RSI_OFF_INTERRUPT_CONTROL_REG) ? {24'h000000, interrupt_control_reg_reg} :
    (paddr == `RSI_OFF_PIRA)   ? {24'h000000, pira_reg} :
    (paddr == `RSI_OFF_PIRB)   ? {24'h000000, pirb_reg} :
    (paddr == `RSI_OFF_CAUSE)  ? {29'h00000000, cause_reg} :
    32'h00000000;

  // ****************************************************************
  // apb answer flops
  // ****************************************************************
  // read data is captured as pready rises, so it stands with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= apb_start;
      pslverr_reg <= apb_start && !mapped;
      if (apb_start) begin
        prdata_reg <= pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

  // ****************************************************************
  // core register flops
  // ****************************************************************
  // async reset loads the power-on values; undefined bits take zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg     <= `RSI_PC_RESET;
      status_reg <= `RSI_ST_RESET;
      power_control_reg_reg   <= 8'h00;
      option_reg <= `RSI_ALL_ONES;
      timer1_control_reg_reg  <= 8'h00;
      pr2_reg    <= `RSI_ALL_ONES;
      interrupt_control_reg_reg <= 8'h00;
      pira_reg   <= 8'h00;
      pirb_reg   <= 8'h00;
      cause_reg  <= rsi_pkg::CAUSE_POR;
    end else begin
      pc_reg     <= pc_next;
      status_reg <= status_next;
      power_control_reg_reg   <= power_control_reg_next;
      option_reg <= option_next;
      timer1_control_reg_reg  <= timer1_control_reg_next;
      pr2_reg    <= pr2_next;
      interrupt_control_reg_reg <= interrupt_control_reg_next;
      pira_reg   <= pira_next;
      pirb_reg   <= pirb_next;
      // keep the last cause so software can see why it restarted
      if (cause != rsi_pkg::CAUSE_NONE) begin
        cause_reg <= cause;
      end
    end
  end

  // ****************************************************************
  // port direction registers
  // ****************************************************************
  // port a has six bits and port e misses bit 3; masks keep those
  // positions zero on every path
  for (genvar i = 0; i < `RSI_NUM_DIRS; i++) begin : g_dir
    localparam logic [7:0] MASK = (i == 0) ? `RSI_MASK_DIR_A :
                                  (i == 4) ? `RSI_MASK_DIR_E :
                                  `RSI_ALL_ONES;
    localparam logic [7:0] RSTV = (i == 4) ? `RSI_DIR_E_RESET : MASK;
    wire hit = apb_wr && dir_hit && (dir_idx == 3'(i));
    wire [7:0] cur = wmerge(hit, dir_reg[i], wd, MASK);
    // every reset turns the pins to inputs
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dir_reg[i] <= RSTV;
      end else begin
        dir_reg[i] <= any_rst ? RSTV : cur;
      end
    end
    assign dir_value[8*i +: 8] = dir_reg[i];
  end

  // ****************************************************************
  // outputs, all straight from flops
  // ****************************************************************
  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign pc_value     = pc_reg;
  assign status_value = status_reg;
  assign power_control_reg_value   = power_control_reg_reg;
  assign option_value = option_reg;
  assign timer1_control_reg_value  = timer1_control_reg_reg;
  assign pr2_value    = pr2_reg;
  assign interrupt_control_reg_value = interrupt_control_reg_reg;
  assign cause_value  = cause_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pin_run_status: assert property (
    cause == rsi_pkg::CAUSE_PIN_RUN && !apb_wr |=> pc_reg == '0 &&
      status_reg[7:5] == 3'b000 &&
      status_reg[4:0] == $past(status_reg[4:0]))
    else $error("pin reset while running set wrong status");
  a_pin_sleep_status: assert property (
    cause == rsi_pkg::CAUSE_PIN_SLEEP |=> pc_reg == '0 &&
      status_reg[7:3] == 5'b00010)
    else $error("pin reset in sleep set wrong status");
  a_irq_wake_bits: assert property (
    irq_wake && !apb_wr |=> status_reg[4:3] == 2'b10 &&
      status_reg[7:5] == $past(status_reg[7:5]))
    else $error("interrupt wake set wrong status");
  a_irq_vector_load: assert property (
    irq_wake && global_irq_enable |=> pc_reg == `RSI_PC_VECTOR)
    else $error("interrupt wake with enable missed vector");
  a_wake_flag_seen: assert property (
    irq_wake |=> (interrupt_control_reg_reg & $past(wake_flags.interrupt_control_reg)) ==
      $past(wake_flags.interrupt_control_reg))
    else $error("wake flag not left set");
  a_unimpl_reads_zero: assert property (
    power_control_reg_reg[7:2] == 6'h00 && timer1_control_reg_reg[7:6] == 2'b00 &&
      pirb_reg[7:1] == 7'h00 && dir_reg[0][7:6] == 2'b00 &&
      dir_reg[4][3] == 1'b0)
    else $error("unimplemented bit reads as one");
  a_full_reset_ones: assert property (
    full_rst |=> option_reg == 8'hff && pr2_reg == 8'hff &&
      pc_reg == '0 && dir_reg[1] == 8'hff)
    else $error("power reset values wrong");
  a_timer1_control_reg_kept: assert property (
    pin_wdt && !apb_wr |=> timer1_control_reg_reg == $past(timer1_control_reg_reg))
    else $error("timer1 control changed on pin or watchdog");
  a_wake_option_kept: assert property (
    any_wake && !apb_wr |=> option_reg == $past(option_reg))
    else $error("option changed on wake");
  a_wdt_reset_bits: assert property (
    cause == rsi_pkg::CAUSE_WDT_RESET |=> status_reg[7:3] == 5'b00001)
    else $error("watchdog reset set wrong status");
  a_por_flag_clear: assert property (
    evt.por |=> power_control_reg_reg[`RSI_POWER_CONTROL_REG_POR] == 1'b0)
    else $error("power-on flag not cleared");
  a_bor_flag_clear: assert property (
    cause == rsi_pkg::CAUSE_BOR |=> power_control_reg_reg[`RSI_POWER_CONTROL_REG_BOR] == 1'b0)
    else $error("brown-out flag not cleared");
  a_cause_priority: assert property (
    evt.por && (evt.bor || evt.pin) |=> cause_reg == rsi_pkg::CAUSE_POR)
    else $error("power-on lost priority");

endmodule

// [test/tb_rsi_reset_init.sv]
// self-checking bench for the reset initializer, driven over apb and events
`timescale 1ns/1ps
`include "rsi_defines.svh"
module tb_rsi_reset_init;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic                 pclk;           // 100 mhz core clock
  logic                 presetn;        // async reset, active low
  logic                 psel;           // apb select
  logic                 penable;        // apb access phase
  logic                 pwrite;         // apb direction
  logic [7:0]           paddr;          // apb byte address
  logic [31:0]          pwdata;         // apb write data
  logic [31:0]          prdata;         // apb read data
  logic                 pready;         // apb completion
  logic                 pslverr;        // apb error
  rsi_pkg::rsi_evt_t    evt;            // detector pulses
  logic                 sleeping;       // core asleep
  rsi_pkg::rsi_flags_t  wake_flags;     // flags raised by the waking source
  logic [12:0]          pc_value;       // program counter toward the core
  logic [7:0]           st_o;           // status toward the core
  logic [7:0]           pw_o;           // power flags toward the core
  logic [7:0]           opt_o;          // option toward the core
  logic [7:0]           t1_o;           // timer1 control toward the core
  logic [7:0]           per_o;          // timer2 period toward the core
  logic [7:0]           ic_o;           // interrupt control toward the core
  logic [39:0]          dir_o;          // port directions toward the core
  rsi_pkg::rsi_cause_t  cause_o;        // last cause toward the core
  logic [31:0]          rdat;           // last read data
  logic                 rerr;           // last response error
  int                   error_cnt;      // mismatches seen
  int                   n_checks;       // comparisons made

  // ****************************************************************
  // device under test
  // ****************************************************************
  rsi_reset_init #(.PC_W(13)) i_rsi_reset_init (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt(evt), .sleeping(sleeping),
    .wake_flags(wake_flags), .pc_value(pc_value), .status_value(st_o),
    .power_control_reg_value(pw_o), .option_value(opt_o), .dir_value(dir_o),
    .timer1_control_reg_value(t1_o), .pr2_value(per_o), .interrupt_control_reg_value(ic_o),
    .cause_value(cause_o)
  );

  // free-running clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  // verdict in one place, also reached on a hung transfer
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // compare four-state values so an unknown never matches
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is taken at the rising edge, before that edge's updates
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("[FAIL] %0t apb transfer hung", $time);
      finish_test();
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // read a register and compare its data and a clean response
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
    chk({31'h0, rerr}, 32'h0);
  endtask

  // one-cycle detector pulse, then one edge for the outputs to update
  task automatic ev(input logic [4:0] e, input logic s,
                    input logic [16:0] f);
    @(posedge pclk);
    evt        <= rsi_pkg::rsi_evt_t'(e);
    sleeping   <= s;
    wake_flags <= rsi_pkg::rsi_flags_t'(f);
    @(posedge pclk);
    evt        <= rsi_pkg::rsi_evt_t'(5'h00);
    @(posedge pclk);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    error_cnt = 0;
    n_checks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, sleeping} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    evt = rsi_pkg::rsi_evt_t'(5'h00);
    wake_flags = rsi_pkg::rsi_flags_t'(17'h00000);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, unmapped and misaligned addresses
    rd(`RSI_OFF_STATUS, 32'h18);
    rd(`RSI_OFF_OPTION, 32'hff);
    rd(`RSI_OFF_DIR0, 32'h3f);
    rd(8'h20, 32'h07);
    rd(`RSI_OFF_PR2, 32'hff);
    rd(`RSI_OFF_CAUSE, 32'h1);
    apb(1'b0, 8'h3c, 32'h0);
    chk({rdat[30:0], rerr}, 32'h1);
    apb(1'b0, 8'h05, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    // unimplemented bits stay zero on writes of all ones
    apb(1'b1, `RSI_OFF_TIMER1_CONTROL_REG, 32'hffffffff);
    apb(1'b1, 8'h20, 32'hff);
    apb(1'b1, `RSI_OFF_POWER_CONTROL_REG, 32'hff);
    apb(1'b1, `RSI_OFF_PIRB, 32'hff);
    rd(`RSI_OFF_TIMER1_CONTROL_REG, 32'h3f);
    rd(8'h20, 32'hf7);
    rd(`RSI_OFF_POWER_CONTROL_REG, 32'h03);
    rd(`RSI_OFF_PIRB, 32'h01);
    $display("test reset and masks done");
    // pin reset while running
    apb(1'b1, `RSI_OFF_OPTION, 32'h55);
    apb(1'b1, `RSI_OFF_DIR0, 32'h00);
    apb(1'b1, `RSI_OFF_STATUS, 32'hff);
    apb(1'b1, `RSI_OFF_PC, 32'h123);
    ev(5'h04, 1'b0, 17'h0);
    chk(32'(pc_value), 32'h0);
    chk(32'(st_o), 32'h1f);
    chk(32'(pw_o), 32'h03);
    chk(32'(opt_o), 32'hff);
    chk(32'(t1_o), 32'h3f);
    chk(32'(per_o), 32'hff);
    chk(32'(ic_o), 32'h00);
    chk(dir_o[31:0], 32'hffffff3f);
    chk(32'(dir_o[39:32]), 32'h07);
    chk(32'(cause_o), 32'h3);
    rd(`RSI_OFF_STATUS, 32'h1f);
    rd(`RSI_OFF_TIMER1_CONTROL_REG, 32'h3f);
    rd(`RSI_OFF_OPTION, 32'hff);
    rd(`RSI_OFF_DIR0, 32'h3f);
    rd(`RSI_OFF_POWER_CONTROL_REG, 32'h03);
    rd(`RSI_OFF_CAUSE, 32'h3);
    // pin reset asleep, then watchdog reset
    apb(1'b1, `RSI_OFF_STATUS, 32'he7);
    ev(5'h04, 1'b1, 17'h0);
    rd(`RSI_OFF_STATUS, 32'h17);
    rd(`RSI_OFF_CAUSE, 32'h4);
    apb(1'b1, `RSI_OFF_STATUS, 32'hff);
    ev(5'h02, 1'b0, 17'h0);
    rd(`RSI_OFF_STATUS, 32'h0f);
    rd(`RSI_OFF_CAUSE, 32'h5);
    $display("test pin and watchdog resets done");
    // watchdog wake: next address, period register back to ones
    apb(1'b1, `RSI_OFF_PC, 32'h010);
    apb(1'b1, `RSI_OFF_STATUS, 32'hff);
    apb(1'b1, `RSI_OFF_PR2, 32'h12);
    ev(5'h02, 1'b1, 17'h0);
    rd(`RSI_OFF_PC, 32'h011);
    rd(`RSI_OFF_STATUS, 32'he7);
    rd(`RSI_OFF_PR2, 32'hff);
    rd(`RSI_OFF_CAUSE, 32'h6);
    // interrupt wake without and with the global enable
    apb(1'b1, `RSI_OFF_INTERRUPT_CONTROL_REG, 32'h00);
    apb(1'b1, `RSI_OFF_PC, 32'h020);
    apb(1'b1, `RSI_OFF_PIRB, 32'h00);
    ev(5'h01, 1'b1, {8'h02, 8'h01, 1'b1});
    rd(`RSI_OFF_PC, 32'h021);
    rd(`RSI_OFF_STATUS, 32'hf7);
    rd(`RSI_OFF_INTERRUPT_CONTROL_REG, 32'h02);
    rd(`RSI_OFF_PIRA, 32'h01);
    rd(`RSI_OFF_PIRB, 32'h01);
    apb(1'b1, `RSI_OFF_INTERRUPT_CONTROL_REG, 32'h80);
    ev(5'h01, 1'b1, {8'h01, 8'h00, 1'b0});
    rd(`RSI_OFF_PC, 32'h004);
    rd(`RSI_OFF_INTERRUPT_CONTROL_REG, 32'h81);
    // an interrupt while running wakes nothing
    apb(1'b1, `RSI_OFF_PC, 32'h030);
    ev(5'h01, 1'b0, {8'h04, 8'h00, 1'b0});
    rd(`RSI_OFF_PC, 32'h030);
    rd(`RSI_OFF_CAUSE, 32'h7);
    $display("test wake-ups done");
    // brown-out, then simultaneous causes
    apb(1'b1, `RSI_OFF_POWER_CONTROL_REG, 32'h03);
    ev(5'h08, 1'b0, 17'h0);
    rd(`RSI_OFF_PC, 32'h0);
    rd(`RSI_OFF_STATUS, 32'h1f);
    rd(`RSI_OFF_POWER_CONTROL_REG, 32'h02);
    rd(`RSI_OFF_TIMER1_CONTROL_REG, 32'h0);
    rd(`RSI_OFF_CAUSE, 32'h2);
    apb(1'b1, `RSI_OFF_POWER_CONTROL_REG, 32'h03);
    ev(5'h18, 1'b0, 17'h0);
    rd(`RSI_OFF_POWER_CONTROL_REG, 32'h01);
    rd(`RSI_OFF_CAUSE, 32'h1);
    ev(5'h06, 1'b0, 17'h0);
    rd(`RSI_OFF_CAUSE, 32'h3);
    $display("test brown-out and priority done");
    finish_test();
  end
endmodule
